// ==== wdx_pkg.sv ====
package wdx_pkg;
	// Channel count and widths
	localparam int          NUM_CH        = 4;
	localparam int          DT_W          = 8;
	localparam int          PINS          = 8;
	localparam int          EV_W          = 8;
	// Fault action encodings
	localparam logic [1:0]  FACT_NONE     = 2'h0;
	localparam logic [1:0]  FACT_CLEARDIR = 2'h3;
	// Restore select encodings
	localparam logic        RESTORE_LATCH = 1'h0;
	localparam logic        RESTORE_CYCLE = 1'h1;
	// Reset values
	localparam logic [7:0]  DT_RST        = 8'h00;
	localparam logic [7:0]  OVR_RST       = 8'h00;
	localparam logic [7:0]  MASK_RST      = 8'h00;
	localparam logic [3:0]  DTEN_RST      = 4'h0;
	// Worst case cycles from event to fault action
	localparam int          FAULT_LAT_CYC = 2;
	// Fault state machine
	typedef enum logic [1:0] {
		WDX_RUN     = 2'b00,
		WDX_FAULT   = 2'b01,
		WDX_RESTORE = 2'b10
	} wdx_fault_e;
endpackage

// ==== wdx_deadtime_gen.sv ====
`timescale 1ns/1ps
// One dead-time generator for a single compare channel
module wdx_deadtime_gen #(
	parameter int DT_W = 8
) (
	input  wire logic            i_core_clk,
	input  wire logic            i_rstn,
	input  wire logic            i_wave,
	input  wire logic [DT_W-1:0] i_low_side_deadtime_value,
	input  wire logic [DT_W-1:0] i_high_side_deadtime_value,
	output logic                 o_low_side_output,
	output logic                 o_high_side_output
);
	logic            wave_reg;
	logic [DT_W-1:0] cnt_reg;
	logic            rise;
	logic            fall;
	logic [DT_W-1:0] cnt_next;

	assign rise = i_wave & ~wave_reg;
	assign fall = ~i_wave & wave_reg;

	// Reload on an edge, else count down and rest at zero
	always_comb begin
		cnt_next = cnt_reg;
		if (rise) begin
			cnt_next = i_low_side_deadtime_value;
		end else if (fall) begin
			cnt_next = i_high_side_deadtime_value;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	// Edge history and counter
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			wave_reg <= 1'b0;
			cnt_reg  <= '0;
		end else begin
			wave_reg <= i_wave;
			cnt_reg  <= cnt_next;
		end
	end

	// Outputs are registered; a zero reload lets the side follow at once
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_low_side_output  <= 1'b0;
			o_high_side_output <= 1'b0;
		end else if (cnt_next != '0) begin
			o_low_side_output  <= 1'b0;
			o_high_side_output <= 1'b0;
		end else begin
			o_low_side_output  <= i_wave;
			o_high_side_output <= ~i_wave;
		end
	end
endmodule

// ==== wdx_waveform_ext.sv ====
`timescale 1ns/1ps
// Operation
// - Dead-time enable splits each enabled channel's waveform output into a complementary pair.
// - Low side follows waveform, high side inverted; both low during dead time.
// - Four identical dead-time generators share one pair of settings.
// - Low and high dead times independent, buffered, copied on update.
// - Eight-bit dead-time counter counts down each cycle, stops at zero.
// - Nonzero dead-time count forces both sides off.
// - Rising edge reloads low-side value, falling edge high-side value.
// - Channel dead-time enable hands pin pair to extension; override enables rule.
// - Pattern mode bypasses dead time and reuses its low-side setting as pattern.
// - In pattern mode, pins with override enable carry channel A waveform.
// - Buffered pattern copied to active only on update condition.
// - Each event channel selectable as fault input; selected ones ORed.
// - Direction-clear action clears direction bits, tri-stating pins; here extension pins get o_pin_oe_n forced high instead.
// - Fault sets fault flag and pulses timer error flag set output.
// - Fault action takes effect within two clock cycles of the event.
// - Fault logic runs with no processor or DMA help, clock needed.
// - Latched restore: wait fault gone and flag cleared, then next update.
// - Cycle restore: wait fault gone, then resume at next update.
// - Leaving fault restores direction bits; override register writes blocked.
// - Lock bit blocks writes to control, override enable and mask.
// - Debug break acts as fault by default; can be disabled.
// - Action code 00 is none, 11 clears direction; 01, 10 reserved.
// - Fault flag cleared only by writing one.
// - Restore select zero is latched, one is cycle-by-cycle.
// - Single-source mode feeds channel A waveform to all generators.
module wdx_waveform_ext #(
	parameter int NUM_CH = wdx_pkg::NUM_CH,
	parameter int DT_W   = wdx_pkg::DT_W,
	parameter int PINS   = wdx_pkg::PINS,
	parameter int EV_W   = wdx_pkg::EV_W
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_rstn,
	// Timer side
	input  wire logic [NUM_CH-1:0] i_waveform_generator,
	input  wire logic              i_update,
	input  wire logic              i_lock_update,
	// Configuration writes
	input  wire logic              i_lock,
	input  wire logic              i_ctrl_we,
	input  wire logic [NUM_CH-1:0] i_channel_deadtime_enable,
	input  wire logic              i_single_source_channel_mode,
	input  wire logic              i_pattern_mode_enable,
	input  wire logic              i_ovr_en_we,
	input  wire logic [PINS-1:0]   i_output_override_enable,
	input  wire logic              i_mask_we,
	input  wire logic [EV_W-1:0]   i_fault_event_mask,
	input  wire logic [1:0]        i_fault_action_select,
	input  wire logic              i_fault_restore_select,
	input  wire logic              i_debug_fault_disable,
	input  wire logic              i_fault_flag_clr,
	input  wire logic              i_dt_low_buf_we,
	input  wire logic [DT_W-1:0]   i_dt_low_buf,
	input  wire logic              i_dt_high_buf_we,
	input  wire logic [DT_W-1:0]   i_dt_high_buf,
	// Fault sources
	input  wire logic [EV_W-1:0]   i_events,
	input  wire logic              i_on_chip_debugger_break,
	// Port side
	input  wire logic [PINS-1:0]   i_port_dir,
	input  wire logic [PINS-1:0]   i_port_out,
	input  wire logic [PINS-1:0]   i_compare_output_enable,
	output logic [PINS-1:0]        o_pin_out,
	output logic [PINS-1:0]        o_pin_oe_n,
	output logic [NUM_CH-1:0]      o_channel_deadtime_enable,
	output logic [PINS-1:0]        o_output_override_enable,
	output logic                   o_single_source_channel_mode,
	output logic                   o_pattern_mode_enable,
	output logic [EV_W-1:0]        o_fault_event_mask,
	output logic [DT_W-1:0]        o_low_side_deadtime_value,
	output logic [DT_W-1:0]        o_high_side_deadtime_value,
	output logic                   o_dt_low_buf_valid,
	output logic                   o_dt_high_buf_valid,
	output logic                   o_fault_flag,
	output logic                   o_timer_error_flag_set,
	output logic                   o_fault_active
);
	typedef wdx_pkg::wdx_fault_e wdx_fault_e_t;

	logic [NUM_CH-1:0] dten_reg;
	logic              ssm_reg;
	logic              pgm_reg;
	logic [PINS-1:0]   ovr_reg;
	logic [EV_W-1:0]   mask_reg;
	logic [DT_W-1:0]   dtl_reg;
	logic [DT_W-1:0]   dth_reg;
	logic [DT_W-1:0]   dtl_buf_reg;
	logic [DT_W-1:0]   dth_buf_reg;
	logic              dtl_v_reg;
	logic              dth_v_reg;
	logic              flag_reg;
	logic              fault_in_reg;
	wdx_fault_e_t      state_reg;
	logic              fault_src;
	logic              prot_on;
	logic              do_update;
	logic              in_fault;
	logic [NUM_CH-1:0] wave_in;
	logic [NUM_CH-1:0] ls;
	logic [NUM_CH-1:0] hs;
	logic [PINS-1:0]   ext_pins;
	logic [PINS-1:0]   dt_val;
	logic [PINS-1:0]   dt_pins;
	logic              ext_active;

	// Reserved action codes behave as protection off
	assign prot_on   = (i_fault_action_select == wdx_pkg::FACT_CLEARDIR);
	// Events of selected channels ORed with debug break unless disabled
	assign fault_src = prot_on & ((|(i_events & mask_reg))
	                 | (i_on_chip_debugger_break & ~i_debug_fault_disable));
	assign do_update = i_update & ~i_lock_update;
	assign in_fault  = (state_reg != wdx_pkg::WDX_RUN);

	// Control, override and mask writes; lock gates all three, fault only the override
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			dten_reg <= wdx_pkg::DTEN_RST;
			ssm_reg  <= 1'b0;
			pgm_reg  <= 1'b0;
			ovr_reg  <= wdx_pkg::OVR_RST;
			mask_reg <= wdx_pkg::MASK_RST;
		end else begin
			if (i_ctrl_we && !i_lock) begin
				dten_reg <= i_channel_deadtime_enable;
				ssm_reg  <= i_single_source_channel_mode;
				pgm_reg  <= i_pattern_mode_enable;
			end
			// Fault leaves the override untouched but refuses writes
			if (i_ovr_en_we && !i_lock && !in_fault) begin
				ovr_reg <= i_output_override_enable;
			end
			if (i_mask_we && !i_lock) begin
				mask_reg <= i_fault_event_mask;
			end
		end
	end

	// Double-buffered dead time / pattern, copied on update only
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			dtl_reg     <= wdx_pkg::DT_RST;
			dth_reg     <= wdx_pkg::DT_RST;
			dtl_buf_reg <= wdx_pkg::DT_RST;
			dth_buf_reg <= wdx_pkg::DT_RST;
			dtl_v_reg   <= 1'b0;
			dth_v_reg   <= 1'b0;
		end else begin
			if (do_update && dtl_v_reg) begin
				dtl_reg <= dtl_buf_reg;
			end
			if (do_update && dth_v_reg) begin
				dth_reg <= dth_buf_reg;
			end
			// A write in the update cycle keeps its valid bit
			if (i_dt_low_buf_we) begin
				dtl_buf_reg <= i_dt_low_buf;
				dtl_v_reg   <= 1'b1;
			end else if (do_update) begin
				dtl_v_reg <= 1'b0;
			end
			if (i_dt_high_buf_we) begin
				dth_buf_reg <= i_dt_high_buf;
				dth_v_reg   <= 1'b1;
			end else if (do_update) begin
				dth_v_reg <= 1'b0;
			end
		end
	end

	// Fault flag: set beats a software clear in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			flag_reg     <= 1'b0;
			fault_in_reg <= 1'b0;
		end else begin
			fault_in_reg <= fault_src;
			if (fault_src) begin
				flag_reg <= 1'b1;
			end else if (i_fault_flag_clr) begin
				flag_reg <= 1'b0;
			end
		end
	end

	// Fault state: entered the cycle after the event, left on update
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			state_reg <= wdx_pkg::WDX_RUN;
		end else begin
			unique case (state_reg)
				wdx_pkg::WDX_RUN: begin
					if (fault_src) begin
						state_reg <= wdx_pkg::WDX_FAULT;
					end
				end
				wdx_pkg::WDX_FAULT: begin
					if (fault_src) begin
						state_reg <= wdx_pkg::WDX_FAULT;
					end else if (i_fault_restore_select == wdx_pkg::RESTORE_CYCLE) begin
						state_reg <= wdx_pkg::WDX_RESTORE;
					end else if (!flag_reg) begin
						state_reg <= wdx_pkg::WDX_RESTORE;
					end
				end
				wdx_pkg::WDX_RESTORE: begin
					if (fault_src) begin
						state_reg <= wdx_pkg::WDX_FAULT;
					end else if (i_update) begin
						state_reg <= wdx_pkg::WDX_RUN;
					end
				end
				default: begin
					state_reg <= wdx_pkg::WDX_RUN;
				end
			endcase
		end
	end

	// Single-source mode feeds channel A everywhere
	assign wave_in = ssm_reg ? {NUM_CH{i_waveform_generator[0]}}
	                         : i_waveform_generator;

	// Four generators sharing the active settings
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_dt
			wdx_deadtime_gen #(
				.DT_W (DT_W)
			) u_dt (
				.i_core_clk                 (i_core_clk),
				.i_rstn                     (i_rstn),
				.i_wave                     (wave_in[g]),
				.i_low_side_deadtime_value  (dtl_reg),
				.i_high_side_deadtime_value (dth_reg),
				.o_low_side_output          (ls[g]),
				.o_high_side_output         (hs[g])
			);
			// Even pin carries low side, odd pin high side
			assign dt_pins[2*g]   = ls[g];
			assign dt_pins[2*g+1] = hs[g];
			assign dt_val[2*g]    = dten_reg[g];
			assign dt_val[2*g+1]  = dten_reg[g];
		end
	endgenerate

	// Pattern mode bypasses dead time; pattern bits come from low setting
	assign ext_pins = pgm_reg ? ({PINS{i_waveform_generator[0]}} & ovr_reg)
	                          | (dtl_reg & ~ovr_reg)
	                          : dt_pins;
	assign ext_active = pgm_reg | (|dten_reg);

	// Pin mux and direction; direction still owned by software
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_pin_out  <= '0;
			o_pin_oe_n <= '1;
		end else begin
			for (int p = 0; p < PINS; p++) begin
				if (ext_active && (pgm_reg || dt_val[p])) begin
					// Pattern bits reach the pin as they stand; dead-time pins need an override
					o_pin_out[p]  <= ext_pins[p] & (ovr_reg[p] | pgm_reg);
					// Direction register must be set for any output
					o_pin_oe_n[p] <= ~i_port_dir[p];
					if (in_fault && prot_on) begin
						o_pin_oe_n[p] <= 1'b1;
					end
				end else begin
					o_pin_out[p]  <= i_port_out[p] & i_compare_output_enable[p];
					o_pin_oe_n[p] <= ~i_port_dir[p];
				end
			end
			// Catch the event cycle itself so the action lands within two cycles
			if (fault_src) begin
				for (int p = 0; p < PINS; p++) begin
					if (pgm_reg || dt_val[p]) begin
						o_pin_oe_n[p] <= 1'b1;
					end
				end
			end
		end
	end

	// Status and configuration visible to software
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_timer_error_flag_set <= 1'b0;
		end else begin
			o_timer_error_flag_set <= fault_src & ~fault_in_reg;
		end
	end

	assign o_channel_deadtime_enable    = dten_reg;
	assign o_output_override_enable     = ovr_reg;
	assign o_single_source_channel_mode = ssm_reg;
	assign o_pattern_mode_enable        = pgm_reg;
	assign o_fault_event_mask           = mask_reg;
	assign o_low_side_deadtime_value    = dtl_reg;
	assign o_high_side_deadtime_value   = dth_reg;
	assign o_dt_low_buf_valid           = dtl_v_reg;
	assign o_dt_high_buf_valid          = dth_v_reg;
	assign o_fault_flag                 = flag_reg;
	assign o_fault_active               = in_fault;
endmodule

// ==== wdx_checker.sv ====
`timescale 1ns/1ps
// Watches the extension's ports for fault, lock and buffer behaviour
module wdx_checker (
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_update,
	input  wire logic       i_lock_update,
	input  wire logic       i_lock,
	input  wire logic [7:0] i_events,
	input  wire logic [1:0] i_fault_action_select,
	input  wire logic       i_fault_flag_clr,
	input  wire logic       i_dt_low_buf_we,
	input  wire logic [7:0] o_pin_out,
	input  wire logic [7:0] o_pin_oe_n,
	input  wire logic [3:0] o_channel_deadtime_enable,
	input  wire logic [7:0] o_output_override_enable,
	input  wire logic       o_pattern_mode_enable,
	input  wire logic [7:0] o_fault_event_mask,
	input  wire logic [7:0] o_low_side_deadtime_value,
	input  wire logic [7:0] o_high_side_deadtime_value,
	input  wire logic       o_dt_low_buf_valid,
	input  wire logic       o_fault_flag,
	input  wire logic       o_timer_error_flag_set,
	input  wire logic       o_fault_active
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	logic [7:0] ext_pins;
	logic [7:0] ext_hi;
	// Pin pairs owned by enabled channels; a fault must tri-state at least these
	always_comb begin
		for (int g = 0; g < 4; g++) ext_pins[2*g +: 2] = {2{o_channel_deadtime_enable[g]}};
	end
	assign ext_hi = o_pin_out & ext_pins;
	a_fault_latency: assert property ((|(i_events & o_fault_event_mask)) &&
		i_fault_action_select == 2'h3 |-> ##[1:2] o_fault_flag) else $error("fault late");
	a_fault_cause: assert property ($rose(o_fault_flag) |->
		$past(i_fault_action_select) == 2'h3 || $past(i_fault_action_select, 2) == 2'h3)
		else $error("fault with action off");
	a_error_single: assert property (o_timer_error_flag_set |=> !o_timer_error_flag_set)
		else $error("error pulse too long");
	a_error_flag: assert property (o_timer_error_flag_set |-> o_fault_flag)
		else $error("error pulse without flag");
	a_flag_w1c: assert property ($fell(o_fault_flag) |-> $past(i_fault_flag_clr))
		else $error("flag cleared without write");
	a_lock_holds: assert property (i_lock |=> $stable(o_channel_deadtime_enable) &&
		$stable(o_output_override_enable) && $stable(o_fault_event_mask))
		else $error("locked register changed");
	a_buf_consumed: assert property (i_update && !i_lock_update && o_dt_low_buf_valid &&
		!i_dt_low_buf_we |=> !o_dt_low_buf_valid) else $error("buffer not copied");
	a_lockupd_hold: assert property (i_lock_update |=> $stable(o_low_side_deadtime_value) &&
		$stable(o_high_side_deadtime_value)) else $error("copy despite lock update");
	a_fault_tristate: assert property (o_fault_active && $past(o_fault_active) &&
		i_fault_action_select == 2'h3 |-> &(o_pin_oe_n | ~ext_pins)) else $error("pin driven");
	a_resume_update: assert property ($fell(o_fault_active) |-> $past(i_update))
		else $error("resume off update");
	a_sides_apart: assert property (!o_pattern_mode_enable |->
		((ext_hi & (ext_hi >> 1)) & 8'h55) == 8'h00) else $error("both sides on");
	c_fault: cover property ($rose(o_fault_active));
	c_resume: cover property ($fell(o_fault_active));
	c_copy: cover property (i_update && o_dt_low_buf_valid && !i_lock_update);
endmodule

// ==== wdx_timer_model.sv ====
`timescale 1ns/1ps
// Stand-in for the timer and port: square waves and update strobes
module wdx_timer_model (
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	output logic [3:0]      o_wave,
	output logic            o_update,
	output logic [7:0]      o_port_dir,
	output logic [7:0]      o_port_out
);
	logic [4:0] cnt_reg;
	// Period of 32 keeps every dead time inside one half period
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) cnt_reg <= 5'h00;
		else cnt_reg <= cnt_reg + 5'h01;
	end
	// Channel 3 in quadrature with 0, channel 2 inverted, channel 1 at twice the rate
	assign o_wave = {cnt_reg[4] ^ cnt_reg[3], ~cnt_reg[4], cnt_reg[3], cnt_reg[4]};
	assign o_update = (cnt_reg == 5'h1f);
	// Software has made every pin an output before the run
	assign o_port_dir = 8'hff;
	assign o_port_out = 8'h00;
endmodule

// ==== wdx_testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic       clk, rstn, upd, lkup, lock, cwe, ss, pm, owe, mwe, rsel, ddis, clr, lwe, hwe;
	logic       brk, lv, hv, flag, err, fact, ssq, pmq;
	logic [1:0] act;
	logic [3:0] wave, den, dq;
	logic [7:0] oin, min, lin, hin, ev, dir, pout, pin, oen, oq, mq, lq, hq;
	int         mismatches, comparisons;
	wdx_timer_model prt (.i_core_clk(clk), .i_rstn(rstn), .o_wave(wave), .o_update(upd),
		.o_port_dir(dir), .o_port_out(pout));
	wdx_waveform_ext dut (.i_core_clk(clk), .i_rstn(rstn), .i_waveform_generator(wave),
		.i_update(upd), .i_lock_update(lkup), .i_lock(lock), .i_ctrl_we(cwe),
		.i_channel_deadtime_enable(den), .i_single_source_channel_mode(ss),
		.i_pattern_mode_enable(pm), .i_ovr_en_we(owe), .i_output_override_enable(oin),
		.i_mask_we(mwe), .i_fault_event_mask(min), .i_fault_action_select(act),
		.i_fault_restore_select(rsel), .i_debug_fault_disable(ddis), .i_fault_flag_clr(clr),
		.i_dt_low_buf_we(lwe), .i_dt_low_buf(lin), .i_dt_high_buf_we(hwe), .i_dt_high_buf(hin),
		.i_events(ev), .i_on_chip_debugger_break(brk), .i_port_dir(dir), .i_port_out(pout),
		.i_compare_output_enable(8'hff), .o_pin_out(pin), .o_pin_oe_n(oen),
		.o_channel_deadtime_enable(dq), .o_output_override_enable(oq),
		.o_single_source_channel_mode(ssq), .o_pattern_mode_enable(pmq),
		.o_fault_event_mask(mq), .o_low_side_deadtime_value(lq),
		.o_high_side_deadtime_value(hq), .o_dt_low_buf_valid(lv), .o_dt_high_buf_valid(hv),
		.o_fault_flag(flag), .o_timer_error_flag_set(err), .o_fault_active(fact));
	// Free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Inputs change 1 ns after the edge so the design never races the bench
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic hang;
		chk(8'h00, 8'h01);
		report_and_stop;
	endtask
	task automatic wait_upd;
		int n;
		n = 0;
		while (upd !== 1'b1 && n < 64) begin
			tick(1);
			n++;
		end
		if (n == 64) hang;
		tick(2);
	endtask
	task automatic wait_clear;
		int n;
		n = 0;
		while (fact !== 1'b0 && n < 80) begin
			tick(1);
			n++;
		end
		if (n == 80) hang;
		tick(2);
	endtask
	task automatic t_reset;
		chk(oen, 8'hff);
		chk({lv, hv, flag, fact, dq}, 8'h00);
	endtask
	// Locked writes must vanish; unlocked ones land
	task automatic t_lock;
		{lock, den, min, oin} = {1'b1, 4'hf, 8'h01, 8'h03};
		{cwe, mwe, owe} = 3'h7;
		tick(1);
		{cwe, mwe, owe, lock} = 4'h0;
		tick(1);
		chk({dq, 4'h0}, 8'h00);
		chk(mq | oq, 8'h00);
		den = 4'h1;
		{cwe, mwe, owe} = 3'h7;
		tick(1);
		{cwe, mwe, owe} = 3'h0;
		tick(1);
		chk({mq[3:0], dq}, 8'h11);
		chk(oq, 8'h03);
	endtask
	task automatic t_buffer;
		{lkup, lin, hin, lwe, hwe} = {1'b1, 8'h03, 8'h02, 2'h3};
		tick(1);
		{lwe, hwe} = 2'h0;
		wait_upd;
		chk(lq | hq, 8'h00);
		chk({6'h00, lv, hv}, 8'h03);
		lkup = 1'b0;
		wait_upd;
		chk({lq[3:0], hq[3:0]}, 8'h32);
		chk({6'h00, lv, hv}, 8'h00);
	endtask
	// Low side of channel 0 must wait out its dead time after a rising edge
	task automatic t_deadtime;
		int n, first, both;
		logic prev;
		{n, both, first, prev} = {32'h0, 32'h0, -32'sd1, 1'b1};
		while (!(prev === 1'b0 && wave[0] === 1'b1) && n < 64) begin
			prev = wave[0];
			tick(1);
			n++;
		end
		if (n == 64) hang;
		for (int k = 1; k <= 24; k++) begin
			tick(1);
			if (pin[0] === 1'b1 && first < 0) first = k;
			if (pin[1:0] !== 2'b00 && pin[1:0] !== 2'b01 && pin[1:0] !== 2'b10) both++;
		end
		chk(8'(first >= 4 && first <= 7), 8'h01);
		chk(8'(both), 8'h00);
	endtask
	// Source held so the fault cannot resume before it is judged
	task automatic t_fault(input logic [1:0] a, input logic b, input logic e);
		{act, rsel, ev, brk} = {a, 1'b1, 7'h00, !b, b};
		tick(1);
		chk({7'h00, err}, {7'h00, e});
		tick(2);
		chk({7'h00, flag}, {7'h00, e});
		if (e) chk({6'h00, oen[1:0]}, 8'h03);
		{ev, brk} = 9'h000;
		wait_clear;
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(1);
		chk({7'h00, flag}, 8'h00);
	endtask
	task automatic t_latched;
		{rsel, act, ev} = {1'b0, 2'h3, 8'h01};
		tick(1);
		ev = 8'h00;
		tick(2);
		{oin, owe} = {8'hff, 1'b1};
		tick(1);
		owe = 1'b0;
		tick(70);
		chk({7'h00, fact}, 8'h01);
		chk(oq, 8'h03);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		wait_clear;
		chk({6'h00, oen[1:0]}, 8'h00);
	endtask
	// Single-source mode: channel B pins follow channel A, high side up while A is low
	task automatic t_single;
		{den, ss, pm, oin} = {4'h2, 1'b1, 1'b0, 8'hff};
		{cwe, owe} = 2'h3;
		tick(1);
		{cwe, owe} = 2'h0;
		wait_upd;
		tick(11);
		chk({ssq, pmq, dq, 2'h0}, 8'h88);
		chk({6'h00, pin[3:2]}, 8'h02);
		chk(oen, 8'h00);
	endtask
	// Pattern mode: override pins carry channel A, the rest the low setting after update
	task automatic t_pattern;
		{den, ss, pm, oin} = {4'h2, 1'b0, 1'b1, 8'h03};
		{cwe, owe} = 2'h3;
		tick(1);
		{cwe, owe} = 2'h0;
		wait_upd;
		{lin, lwe} = {8'ha4, 1'b1};
		tick(1);
		lwe = 1'b0;
		tick(1);
		chk(pin & 8'hfc, 8'h00);
		wait_upd;
		chk(pin & 8'hfc, 8'ha4);
		chk(pin & 8'h03, 8'h00);
		tick(18);
		chk(pin & 8'h03, 8'h03);
	endtask
	// Main sequence: ten cycles of reset, then each scenario in turn
	initial begin
		{rstn, lkup, lock, cwe, ss, pm, owe, mwe, rsel, ddis, clr, lwe, hwe, brk} = '0;
		{act, den, oin, min, lin, hin, ev, mismatches, comparisons} = '0;
		tick(10);
		rstn = 1'b1;
		t_reset;
		t_lock;
		t_buffer;
		t_deadtime;
		for (int a = 0; a < 4; a++) t_fault(2'(a), 1'b0, a == 3);
		t_fault(2'h3, 1'b1, 1'b1);
		ddis = 1'b1;
		t_fault(2'h3, 1'b1, 1'b0);
		t_latched;
		t_single;
		t_pattern;
		report_and_stop;
	end
endmodule
bind wdx_waveform_ext wdx_checker u_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
	.i_update(i_update), .i_lock_update(i_lock_update), .i_lock(i_lock), .i_events(i_events),
	.i_fault_action_select(i_fault_action_select), .i_fault_flag_clr(i_fault_flag_clr),
	.i_dt_low_buf_we(i_dt_low_buf_we), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
	.o_channel_deadtime_enable(o_channel_deadtime_enable),
	.o_output_override_enable(o_output_override_enable),
	.o_pattern_mode_enable(o_pattern_mode_enable), .o_fault_event_mask(o_fault_event_mask),
	.o_low_side_deadtime_value(o_low_side_deadtime_value),
	.o_high_side_deadtime_value(o_high_side_deadtime_value),
	.o_dt_low_buf_valid(o_dt_low_buf_valid), .o_fault_flag(o_fault_flag),
	.o_timer_error_flag_set(o_timer_error_flag_set), .o_fault_active(o_fault_active));
